// ===== chip_prot_params.svh
`ifndef CHIP_PROT_PARAMS_SVH
`define CHIP_PROT_PARAMS_SVH
`define CPC_REG_ADDR      8'hda
`define CPC_SFR_BASE      8'h80
`define CPC_RESET_VALUE   8'h20
`define CPC_WRITE_MASK    8'hdf
`define CPC_BIT_PROG_LOCK 7
`define CPC_BIT_DBG_OFF   6
`define CPC_BIT_RESERVED  5
`define CPC_BIT_OTP_LOCK  4
`define CPC_BIT_WR_LOCK   3
`define CPC_LVL_MSB       2
`define CPC_LVL_LSB       0
`define CPC_LVL_FACTORY   3'b001
`define CPC_LVL_USER      3'b011
`define CPC_LVL_RUN       3'b111
`define CPC_RUN_PREFIX    2'b11
`endif

// ===== chip_prot_pkg.sv
package chip_prot_pkg;
   // program level codes
   typedef enum logic [2:0] {
      level_blank_e   = 3'b000,
      level_factory_e = 3'b001,
      level_user_e    = 3'b011,
      level_run_e     = 3'b111
   } program_level_t;

   // field layout of the protection register
   typedef struct packed {
      logic       program_memory_lock;
      logic       debug_port_disable;
      logic       reserved_one;
      logic       otp_memory_lock;
      logic       program_memory_write_lock;
      logic [2:0] program_level;
   } prot_fields_t;

   // registers whose address ends in 0x0 or 0x8 take bit access
   function automatic logic is_bit_capable(input logic [7:0] addr);
      is_bit_capable = (addr[2:0] == 3'h0);
   endfunction
endpackage

// ===== sfr_sel_if.sv
`timescale 1ns/1ns
interface sfr_sel_if;
   logic       byte_wr;
   logic       byte_rd;
   logic       bit_wr;
   logic [2:0] bit_idx;
   modport dec  (output byte_wr, output byte_rd, output bit_wr, output bit_idx);
   modport core (input byte_wr, input byte_rd, input bit_wr, input bit_idx);
endinterface

// ===== sfr_decode.sv
`timescale 1ns/1ns
`include "chip_prot_params.svh"
module sfr_decode
   import chip_prot_pkg::*;
#(
   parameter logic [7:0] REG_ADDR = `CPC_REG_ADDR
) (
   input  wire logic [7:0] sfr_addr,
   input  wire logic       direct_mode,
   input  wire logic       sfr_byte_wr,
   input  wire logic       sfr_byte_rd,
   input  wire logic       sfr_bit_wr,
   sfr_sel_if.dec          sel
);
   // refuse a register placed outside the special function space
   if (REG_ADDR < `CPC_SFR_BASE) begin : g_addr_check
      $error("register address lies below the special function space");
   end

   // direct accesses with the top address bit set reach the sfr space
   wire in_sfr   = direct_mode & sfr_addr[7];
   wire byte_hit = in_sfr & (sfr_addr == REG_ADDR);
   // bit address carries register bits 7:3 and the bit number in 2:0
   wire bit_hit  = in_sfr & is_bit_capable(REG_ADDR)
                   & (sfr_addr[7:3] == REG_ADDR[7:3]);

   assign sel.byte_wr = byte_hit & sfr_byte_wr;
   assign sel.byte_rd = byte_hit & sfr_byte_rd;
   assign sel.bit_wr  = bit_hit & sfr_bit_wr;
   assign sel.bit_idx = sfr_addr[2:0];
endmodule

// ===== chip_protection_control.sv
`timescale 1ns/1ns
`include "chip_prot_params.svh"
module chip_protection_control
   import chip_prot_pkg::*;
#(
   parameter logic [7:0] REG_ADDR = `CPC_REG_ADDR
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       wake_from_shutdown,
   input  wire logic       boot_load,
   input  wire logic [7:0] boot_value,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       direct_mode,
   input  wire logic       sfr_byte_wr,
   input  wire logic       sfr_byte_rd,
   input  wire logic       sfr_bit_wr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_bit_val,
   input  wire logic [7:0] otp_rdata_raw,
   output wire logic [7:0] sfr_rdata,
   output wire logic       sfr_rsel,
   output wire logic       nvm_read_allow,
   output wire logic       nvm_write_allow,
   output wire logic [7:0] otp_rdata,
   output wire logic       debug_port_enable,
   output wire logic       retest_allow,
   output wire logic [2:0] level_out
);
   ////////////////////////////////////////////////////////////////////////////
   // address decode
   sfr_sel_if sel ();

   sfr_decode #(
      .REG_ADDR    (REG_ADDR)
   ) u_decode (
      .sfr_addr    (sfr_addr),
      .direct_mode (direct_mode),
      .sfr_byte_wr (sfr_byte_wr),
      .sfr_byte_rd (sfr_byte_rd),
      .sfr_bit_wr  (sfr_bit_wr),
      .sel         (sel.dec)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register update, bits only set except the debug disable bit cleared on wake
   logic [7:0] prot_r;
   logic [7:0] prot_nxt;
   logic [7:0] sfr_rdata_r;
   logic       sfr_rsel_r;
   logic       nvm_read_allow_r;
   logic       nvm_write_allow_r;
   logic [7:0] otp_rdata_r;
   logic       debug_port_enable_r;
   logic       retest_allow_r;
   logic [2:0] level_r;
   prot_fields_t fld;

   localparam logic [7:0] WRITE_MASK = `CPC_WRITE_MASK;
   localparam logic [7:0] DBG_MASK   = 8'h01 << `CPC_BIT_DBG_OFF;

   // ones set bits, zeros leave them; reserved bit is never writable
   wire [7:0] byte_set  = sel.byte_wr ? (sfr_wdata & WRITE_MASK) : 8'h00;
   wire [7:0] bit_one   = 8'h01 << sel.bit_idx;
   wire [7:0] bit_set   = (sel.bit_wr & sfr_bit_val) ? (bit_one & WRITE_MASK)
                                                     : 8'h00;
   wire [7:0] boot_set  = boot_load ? (boot_value & WRITE_MASK) : 8'h00;
   wire [7:0] set_mask  = byte_set | bit_set | boot_set;
   // shutdown wake clears only the debug disable bit, a same-cycle set wins
   wire [7:0] clr_mask  = wake_from_shutdown ? (DBG_MASK & ~set_mask) : 8'h00;
   assign prot_nxt      = (prot_r | set_mask) & ~clr_mask;
   assign fld           = prot_t_cast(prot_r);

   function automatic prot_fields_t prot_t_cast(input logic [7:0] v);
      prot_t_cast = v;
   endfunction

   // protection register, bit five resets to one and is never cleared
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prot_r <= `CPC_RESET_VALUE;
      end else begin
         prot_r <= prot_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // access gating derived from the stored fields
   wire run_level   = (fld.program_level[2:1] == `CPC_RUN_PREFIX);
   wire rd_ok_nxt   = ~fld.program_memory_lock;
   wire wr_ok_nxt   = ~fld.program_memory_lock
                      & ~(fld.program_memory_write_lock & run_level);
   wire [7:0] otp_nxt = fld.otp_memory_lock ? 8'h00 : otp_rdata_raw;
   wire dbg_ok_nxt  = ~fld.debug_port_disable;
   wire [7:0] rd_nxt = sel.byte_rd ? prot_r : 8'h00;

   // registered outputs, they trail the register by one clock
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         nvm_read_allow_r    <= 1'b0;
         nvm_write_allow_r   <= 1'b0;
         otp_rdata_r         <= 8'h00;
         debug_port_enable_r <= 1'b0;
         retest_allow_r      <= 1'b0;
         level_r             <= 3'h0;
         sfr_rdata_r         <= 8'h00;
         sfr_rsel_r          <= 1'b0;
      end else begin
         nvm_read_allow_r    <= rd_ok_nxt;
         nvm_write_allow_r   <= wr_ok_nxt;
         otp_rdata_r         <= otp_nxt;
         debug_port_enable_r <= dbg_ok_nxt;
         retest_allow_r      <= dbg_ok_nxt;
         level_r             <= fld.program_level;
         sfr_rdata_r         <= rd_nxt;
         sfr_rsel_r          <= sel.byte_rd;
      end
   end

   assign nvm_read_allow    = nvm_read_allow_r;
   assign nvm_write_allow   = nvm_write_allow_r;
   assign otp_rdata         = otp_rdata_r;
   assign debug_port_enable = debug_port_enable_r;
   assign retest_allow      = retest_allow_r;
   assign level_out         = level_r;
   assign sfr_rdata         = sfr_rdata_r;
   assign sfr_rsel          = sfr_rsel_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_prog_lock;
      prot_r[`CPC_BIT_PROG_LOCK] |=> (!nvm_read_allow && !nvm_write_allow);
   endproperty
   a_prog_lock: assert property (p_prog_lock) else $error("locked memory still open");

   property p_bit_sticky;
      prot_r[`CPC_BIT_OTP_LOCK] |=> prot_r[`CPC_BIT_OTP_LOCK] [*2];
   endproperty
   a_bit_sticky: assert property (p_bit_sticky) else $error("otp lock cleared");

   property p_dbg_clear;
      $fell(prot_r[`CPC_BIT_DBG_OFF]) |-> $past(wake_from_shutdown);
   endproperty
   a_dbg_clear: assert property (p_dbg_clear)
      else $error("debug disable fell without wake");

   property p_dbg_off;
      prot_r[`CPC_BIT_DBG_OFF] |=> (!debug_port_enable && !retest_allow);
   endproperty
   a_dbg_off: assert property (p_dbg_off) else $error("debug reachable while disabled");

   property p_otp_zero;
      prot_r[`CPC_BIT_OTP_LOCK] |=> (otp_rdata == 8'h00);
   endproperty
   a_otp_zero: assert property (p_otp_zero) else $error("otp data leaked");

   property p_wr_lock_ignored;
      (prot_r[3] && prot_r[2:1] != 2'b11 && !prot_r[7]) |=> nvm_write_allow;
   endproperty
   a_wr_lock_ignored: assert property (p_wr_lock_ignored)
      else $error("write lock honoured off Run");

   property p_wr_lock_run;
      (prot_r[3] && prot_r[2:1] == 2'b11) |=> !nvm_write_allow;
   endproperty
   a_wr_lock_run: assert property (p_wr_lock_run)
      else $error("write lock ignored at Run");

   property p_level_up;
      1'b1 |=> ((prot_r[2:0] & $past(prot_r[2:0])) == $past(prot_r[2:0]));
   endproperty
   a_level_up: assert property (p_level_up) else $error("program level bit cleared");

   property p_non_sfr;
      (sfr_byte_wr && direct_mode && !sfr_addr[7] && !boot_load && !sfr_bit_wr
       && !wake_from_shutdown) |=> (prot_r == $past(prot_r));
   endproperty
   a_non_sfr: assert property (p_non_sfr)
      else $error("write below sfr space took effect");

   property p_no_bit_access;
      (!is_bit_capable(REG_ADDR) && sfr_bit_wr && !sfr_byte_wr && !boot_load
       && !wake_from_shutdown) |=> (prot_r == $past(prot_r));
   endproperty
   a_no_bit_access: assert property (p_no_bit_access)
      else $error("bit write on byte register");

   // masked boot value captured for the load check
   logic [7:0] boot_seen_r;
   always_ff @(posedge clk) begin
      boot_seen_r <= boot_value & WRITE_MASK;
   end

   property p_boot_load;
      boot_load |=> ((prot_r & boot_seen_r) == boot_seen_r);
   endproperty
   a_boot_load: assert property (p_boot_load) else $error("boot value not loaded");

   property p_read_back;
      sel.byte_rd |=> (sfr_rsel && sfr_rdata == $past(prot_r));
   endproperty
   a_read_back: assert property (p_read_back) else $error("read data wrong");

   property p_no_fall;
      1'b1 |=> (((prot_r | DBG_MASK) & $past(prot_r)) == $past(prot_r));
   endproperty
   a_no_fall: assert property (p_no_fall) else $error("protection weakened");

   property p_reserved;
      prot_r[`CPC_BIT_RESERVED] && !sfr_rdata[`CPC_BIT_RESERVED] |-> !sfr_rsel;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit read zero");

   property p_reserved_one;
      prot_r[`CPC_BIT_RESERVED];
   endproperty
   a_reserved_one: assert property (p_reserved_one) else $error("reserved bit not one");

   property p_otp_pass;
      !prot_r[`CPC_BIT_OTP_LOCK] |=> (otp_rdata == $past(otp_rdata_raw));
   endproperty
   a_otp_pass: assert property (p_otp_pass) else $error("otp data not passed");

   c_run_level:  cover property (prot_r[2:0] == `CPC_LVL_RUN);
   c_dbg_wake:   cover property ($fell(prot_r[`CPC_BIT_DBG_OFF]));
   c_full_lock:  cover property (prot_r[`CPC_BIT_PROG_LOCK] && prot_r[`CPC_BIT_OTP_LOCK]);
   c_read:       cover property (sfr_rsel);
endmodule

// ===== tb_chip_protection_control.sv
`timescale 1ns/1ns
module tb_chip_protection_control
   import chip_prot_pkg::*;
;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic       wake_from_shutdown = 1'b0;
   logic       boot_load = 1'b0;
   logic [7:0] boot_value = 8'h00;
   logic [7:0] sfr_addr = 8'h00;
   logic       direct_mode = 1'b0;
   logic       sfr_byte_wr = 1'b0;
   logic       sfr_byte_rd = 1'b0;
   logic       sfr_bit_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic       sfr_bit_val = 1'b0;
   logic [7:0] otp_rdata_raw = 8'h5a;
   wire  [7:0] sfr_rdata;
   wire        sfr_rsel;
   wire        nvm_read_allow;
   wire        nvm_write_allow;
   wire  [7:0] otp_rdata;
   wire        debug_port_enable;
   wire        retest_allow;
   wire  [2:0] level_out;
   int         bad_count = 0;
   int         compares = 0;
   int         cycles = 0;

   ////////////////////////////////////////////////////////////////////////////
   // clock, cycle ceiling and device under test
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count = bad_count + 1;
         report_and_stop();
      end
   end
   chip_protection_control u_dut (
      .clk(clk), .reset(reset), .wake_from_shutdown(wake_from_shutdown),
      .boot_load(boot_load), .boot_value(boot_value), .sfr_addr(sfr_addr),
      .direct_mode(direct_mode), .sfr_byte_wr(sfr_byte_wr), .sfr_byte_rd(sfr_byte_rd),
      .sfr_bit_wr(sfr_bit_wr), .sfr_wdata(sfr_wdata), .sfr_bit_val(sfr_bit_val),
      .otp_rdata_raw(otp_rdata_raw), .sfr_rdata(sfr_rdata), .sfr_rsel(sfr_rsel),
      .nvm_read_allow(nvm_read_allow), .nvm_write_allow(nvm_write_allow),
      .otp_rdata(otp_rdata), .debug_port_enable(debug_port_enable),
      .retest_allow(retest_allow), .level_out(level_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   // byte write, returns once gating outputs show the new register
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dm);
      sfr_addr = a;
      sfr_wdata = d;
      direct_mode = dm;
      sfr_byte_wr = 1'b1;
      step();
      sfr_byte_wr = 1'b0;
      direct_mode = 1'b1;
      step();
   endtask
   // byte read with a bounded wait for the select pulse
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit_exp);
      logic       hit;
      logic [7:0] v;
      hit = 1'b0;
      v = 8'h00;
      sfr_addr = a;
      direct_mode = 1'b1;
      sfr_byte_rd = 1'b1;
      step();
      sfr_byte_rd = 1'b0;
      repeat (2) begin
         if (!hit && sfr_rsel === 1'b1) begin
            hit = 1'b1;
            v = sfr_rdata;
         end
         if (!hit) step();
      end
      chk({7'h00, hit}, {7'h00, hit_exp});
      if (hit_exp) chk(v, exp);
      step();
   endtask
   task automatic do_reset();
      reset = 1'b1;
      repeat (6) step();
      reset = 1'b0;
      step();
   endtask
   task automatic gates(input logic [7:0] exp);
      chk({4'h0, nvm_read_allow, nvm_write_allow, debug_port_enable, retest_allow}, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   localparam logic [2:0] CPC_FACTORY = 3'b001;
   task automatic t_reset_state();
      rd(8'hda, 8'h20, 1'b1);
      gates(8'h0f);
      chk({5'h00, level_out}, 8'h00);
   endtask
   task automatic t_decode();
      wr(8'h5a, 8'hff, 1'b1);
      wr(8'hda, 8'hff, 1'b0);
      sfr_addr = 8'hda;
      sfr_bit_val = 1'b1;
      sfr_bit_wr = 1'b1;
      step();
      sfr_bit_wr = 1'b0;
      step();
      rd(8'hda, 8'h20, 1'b1);
      rd(8'h5a, 8'h00, 1'b0);
      gates(8'h0f);
   endtask
   task automatic t_level();
      wr(8'hda, 8'h01, 1'b1);
      chk({5'h00, level_out}, {5'h00, CPC_FACTORY});
      wr(8'hda, 8'h08, 1'b1);
      wr(8'hda, 8'h02, 1'b1);
      chk({5'h00, level_out}, 8'h03);
      gates(8'h0f);
      wr(8'hda, 8'h00, 1'b1);
      chk({5'h00, level_out}, 8'h03);
      wr(8'hda, 8'h04, 1'b1);
      chk({5'h00, level_out}, 8'h07);
      gates(8'h0b);
      rd(8'hda, 8'h2f, 1'b1);
   endtask
   task automatic t_otp();
      step();
      chk(otp_rdata, 8'h5a);
      wr(8'hda, 8'h10, 1'b1);
      chk(otp_rdata, 8'h00);
   endtask
   task automatic t_debug();
      wr(8'hda, 8'h40, 1'b1);
      gates(8'h08);
      wr(8'hda, 8'h00, 1'b1);
      gates(8'h08);
      wake_from_shutdown = 1'b1;
      step();
      wake_from_shutdown = 1'b0;
      step();
      gates(8'h0b);
      rd(8'hda, 8'h3f, 1'b1);
      // a set in the same cycle as a wake must win
      sfr_addr = 8'hda;
      sfr_wdata = 8'h40;
      sfr_byte_wr = 1'b1;
      wake_from_shutdown = 1'b1;
      step();
      sfr_byte_wr = 1'b0;
      wake_from_shutdown = 1'b0;
      step();
      gates(8'h08);
      wake_from_shutdown = 1'b1;
      step();
      wake_from_shutdown = 1'b0;
      step();
      gates(8'h0b);
   endtask
   task automatic t_lock();
      wr(8'hda, 8'h80, 1'b1);
      gates(8'h03);
      wr(8'hda, 8'h00, 1'b1);
      rd(8'hda, 8'hbf, 1'b1);
   endtask
   task automatic t_boot();
      wr(8'hda, 8'h40, 1'b1);
      do_reset();
      gates(8'h0f);
      boot_value = 8'hd3;
      boot_load = 1'b1;
      step();
      boot_load = 1'b0;
      step();
      rd(8'hda, 8'hf3, 1'b1);
      gates(8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      do_reset();
      t_reset_state();
      t_decode();
      t_level();
      t_otp();
      t_debug();
      t_lock();
      t_boot();
      report_and_stop();
   end
endmodule
